// *** src/gcr_cfg.svh ***
/*
  constants for the low global configuration registers: indices, field
  positions, reset values and fixed read bits.
  assumes inclusion by bare name from design files only.
*/
`ifndef GCR_CFG_SVH
`define GCR_CFG_SVH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define GCR_IDX_ZERO       8'h00
`define GCR_IDX_ONE        8'h01
`define GCR_IDX_TWO        8'h02
`define GCR_IDX_THREE      8'h03
`define GCR_IDX_LOCK_LAST  8'h2f

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define GCR_RST_ZERO       8'h28
`define GCR_RST_ONE        8'h9c
`define GCR_RST_TWO        8'h88
`define GCR_RST_THREE      8'h70

// ----------------------------------------------------------------------
// writable bit masks and fixed read values
// ----------------------------------------------------------------------
`define GCR_WMASK_ZERO     8'h80
`define GCR_FIXED_ZERO     8'h28
`define GCR_WMASK_ONE      8'h8c
`define GCR_FIXED_ONE      8'h10
`define GCR_WMASK_TWO      8'h88
`define GCR_FIXED_TWO      8'h00
`define GCR_WMASK_THREE    8'h85
`define GCR_FIXED_THREE    8'h70

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define GCR_BIT_VALID      7
`define GCR_BIT_PAR_PWR    2
`define GCR_BIT_PAR_MODE   3
`define GCR_BIT_LOCK       7
`define GCR_BIT_SER1_PWR   3
`define GCR_BIT_SER2_PWR   7
`define GCR_BIT_PGOOD_SEL  0
`define GCR_BIT_PIN_HI     7
`define GCR_BIT_PIN_LO     2
`define GCR_BIT_ZERO3      3

// value read while the lock hides the registers
`define GCR_LOCKED_READ    8'hff

`endif

// *** src/gcr_pkg.sv ***
/*
  types for the low global configuration registers.
  assumes gcr_cfg.svh supplies the numeric constants.
*/
package gcr_pkg;

  // function of the shared pin
  typedef enum logic [1:0] {
    GCR_PIN_DEFAULT  = 2'b00,
    GCR_PIN_RESERVED = 2'b01,
    GCR_PIN_ADDR_QUAL = 2'b10,
    GCR_PIN_AUX_IRQ  = 2'b11
  } gcr_pin_fn_t;

  // host register access request
  typedef struct packed {
    logic       cfg_state;
    logic [7:0] index;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } gcr_req_t;

  // controls handed to the function blocks
  typedef struct packed {
    logic        par_power;
    logic        par_printer_mode;
    logic        ser1_power;
    logic        ser2_power;
    logic        pgood_reserved;
    gcr_pin_fn_t pin_fn;
    logic        valid_flag;
  } gcr_ctl_t;

endpackage

// *** src/gcr_dev_gate.sv ***
/*
  power gating of one logical device: pins off when powered down,
  address decode kept while the base address stays valid.
  assumes the base address and the raw decode come from the same clock.
*/
`timescale 1ns/1ps
module gcr_dev_gate
  import gcr_pkg::*;
#(
  parameter int ADDR_W   = 11,
  parameter int MIN_BASE = 256
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // control
  input  wire logic              power_on,
  input  wire logic [ADDR_W-1:0] base_addr,
  input  wire logic              addr_hit,
  // results
  output logic                   dev_enable_q,
  output logic                   decode_en_q,
  output logic                   range_check_q
);

  wire base_valid = (base_addr >= ADDR_W'(MIN_BASE));

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dev_enable_q  <= 1'b0;
      decode_en_q   <= 1'b0;
      range_check_q <= 1'b0;
    end else begin
      dev_enable_q  <= power_on;
      // decode follows the base address and the raw hit, not the power bit
      decode_en_q   <= base_valid & addr_hit;
      // powered-down device still joins range checking
      range_check_q <= base_valid;
    end
  end

  gate_pwr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !power_on ##1 1 |-> !dev_enable_q) else $error("device enabled while powered down");
  gate_range_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (base_valid && !power_on) |=> range_check_q) else $error("range check dropped");
  gate_on_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    power_on |=> dev_enable_q) else $error("device off while powered");
  decode_keep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (base_valid && addr_hit && !power_on) |=> decode_en_q) else $error("decode lost at power down");
  decode_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !base_valid |=> (!decode_en_q && !range_check_q)) else $error("decode below base limit");

endmodule

// *** src/gcr_regs.sv ***
/*
  low global configuration registers zero to three, with lock, power
  controls and pin-function selects; three power gates instantiated.
  assumes the host interface presents single-cycle read/write strobes
  in ref_clk, and that configuration-state entry is decided outside.
*/
`timescale 1ns/1ps
`include "gcr_cfg.svh"
module gcr_regs
  import gcr_pkg::*;
#(
  parameter int ADDR_W = 11
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // host register access
  input  wire gcr_req_t          req,
  output logic [7:0]             rdata_q,
  output logic                   rvalid_q,
  // base addresses and raw decodes of the logical devices
  input  wire logic [ADDR_W-1:0] par_base,
  input  wire logic [ADDR_W-1:0] ser1_base,
  input  wire logic [ADDR_W-1:0] ser2_base,
  input  wire logic              par_hit,
  input  wire logic              ser1_hit,
  input  wire logic              ser2_hit,
  // controls to function blocks
  output gcr_ctl_t               ctl_q,
  output logic [2:0]             dev_enable_q,
  output logic [2:0]             decode_en_q,
  output logic [2:0]             range_check_q,
  // current lock state
  output logic                   unlocked_q
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0] reg_zero_q, reg_one_q, reg_two_q, reg_three_q;
  logic [7:0] reg_zero_d, reg_one_d, reg_two_d, reg_three_d;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire lock_open  = reg_one_q[`GCR_BIT_LOCK];
  wire in_locked  = (req.index <= `GCR_IDX_LOCK_LAST);
  // config state must be active, and the lock open unless the index is above GCR_IDX_LOCK_LAST
  wire acc_ok     = req.cfg_state & (lock_open | ~in_locked);
  wire wr_ok      = acc_ok & req.wr;
  wire sel_zero   = (req.index == `GCR_IDX_ZERO);
  wire sel_one    = (req.index == `GCR_IDX_ONE);
  wire sel_two    = (req.index == `GCR_IDX_TWO);
  wire sel_three  = (req.index == `GCR_IDX_THREE);
  wire mine       = sel_zero | sel_one | sel_two | sel_three;

  // only writable bits are stored; fixed bits come back on read
  assign reg_zero_d  = (wr_ok & sel_zero)
                     ? (req.wdata & `GCR_WMASK_ZERO) : reg_zero_q;
  // the lock bit may only fall, never rise, by a write
  wire [7:0] one_wr  = req.wdata & `GCR_WMASK_ONE;
  wire [7:0] one_new = {one_wr[7] & reg_one_q[7], one_wr[6:0]};
  assign reg_one_d   = (wr_ok & sel_one)   ? one_new : reg_one_q;
  assign reg_two_d   = (wr_ok & sel_two)
                     ? (req.wdata & `GCR_WMASK_TWO) : reg_two_q;
  assign reg_three_d = (wr_ok & sel_three)
                     ? (req.wdata & `GCR_WMASK_THREE) : reg_three_q;

  // read mux with fixed bits merged in
  wire [7:0] rd_zero  = (reg_zero_q  & `GCR_WMASK_ZERO)  | `GCR_FIXED_ZERO;
  wire [7:0] rd_one   = (reg_one_q   & `GCR_WMASK_ONE)   | `GCR_FIXED_ONE;
  wire [7:0] rd_two   = (reg_two_q   & `GCR_WMASK_TWO)   | `GCR_FIXED_TWO;
  wire [7:0] rd_three = (reg_three_q & `GCR_WMASK_THREE) | `GCR_FIXED_THREE;
  wire [7:0] rd_sel   = sel_zero ? rd_zero :
                        sel_one  ? rd_one  :
                        sel_two  ? rd_two  : rd_three;
  // locked reads return a fixed pattern instead of contents
  wire [7:0] rd_val   = acc_ok ? rd_sel : `GCR_LOCKED_READ;
  wire       rd_go    = req.rd & req.cfg_state & mine;

  // pin function pair taken from bits 7 and 2
  wire [1:0] pin_sel  = {reg_three_q[`GCR_BIT_PIN_HI], reg_three_q[`GCR_BIT_PIN_LO]};

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_zero_q  <= `GCR_RST_ZERO & `GCR_WMASK_ZERO;
      reg_one_q   <= `GCR_RST_ONE & `GCR_WMASK_ONE;
      reg_two_q   <= `GCR_RST_TWO & `GCR_WMASK_TWO;
      reg_three_q <= `GCR_RST_THREE & `GCR_WMASK_THREE;
    end else begin
      reg_zero_q  <= reg_zero_d;
      reg_one_q   <= reg_one_d;
      reg_two_q   <= reg_two_d;
      reg_three_q <= reg_three_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_go;
      rdata_q  <= rd_go ? rd_val : 8'h00;
    end
  end

  // controls follow the stored bits one cycle later
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctl_q      <= '{par_power: 1'b1, par_printer_mode: 1'b1, ser1_power: 1'b1,
                      ser2_power: 1'b1, pgood_reserved: 1'b0, pin_fn: GCR_PIN_DEFAULT,
                      valid_flag: 1'b0};
      unlocked_q <= 1'b1;
    end else begin
      ctl_q.par_power        <= reg_one_q[`GCR_BIT_PAR_PWR];
      ctl_q.par_printer_mode <= reg_one_q[`GCR_BIT_PAR_MODE];
      ctl_q.ser1_power       <= reg_two_q[`GCR_BIT_SER1_PWR];
      ctl_q.ser2_power       <= reg_two_q[`GCR_BIT_SER2_PWR];
      ctl_q.pgood_reserved   <= reg_three_q[`GCR_BIT_PGOOD_SEL];
      ctl_q.pin_fn           <= gcr_pin_fn_t'(pin_sel);
      // valid flag is exported for software visibility only
      ctl_q.valid_flag       <= reg_zero_q[`GCR_BIT_VALID];
      unlocked_q             <= lock_open;
    end
  end

  // ----------------------------------------------------------------------
  // power gates for parallel, primary serial, secondary serial
  // ----------------------------------------------------------------------
  wire [2:0]        pwr_bits = {reg_two_q[`GCR_BIT_SER2_PWR], reg_two_q[`GCR_BIT_SER1_PWR],
                                reg_one_q[`GCR_BIT_PAR_PWR]};
  wire [2:0]        hits     = {ser2_hit, ser1_hit, par_hit};
  wire [ADDR_W-1:0] bases [3];
  assign bases[0] = par_base;
  assign bases[1] = ser1_base;
  assign bases[2] = ser2_base;

  for (genvar g = 0; g < 3; g++) begin : g_gate
    gcr_dev_gate #(
      .ADDR_W   (ADDR_W),
      .MIN_BASE (256)
    ) u_gate (
      .ref_clk       (ref_clk),
      .reset_n       (reset_n),
      .power_on      (pwr_bits[g]),
      .base_addr     (bases[g]),
      .addr_hit      (hits[g]),
      .dev_enable_q  (dev_enable_q[g]),
      .decode_en_q   (decode_en_q[g]),
      .range_check_q (range_check_q[g])
    );
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  lock_sticky_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !reg_one_q[7] |=> !reg_one_q[7]) else $error("lock bit rose without reset");
  locked_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.wr && !lock_open && sel_two) |=> $stable(reg_two_q)) else $error("locked write stored");
  no_cfg_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.wr && !req.cfg_state && sel_zero) |=> $stable(reg_zero_q)) else $error("write outside config");
  locked_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (rd_go && !lock_open) |=> rdata_q == `GCR_LOCKED_READ) else $error("locked read leaked");
  zero_fixed_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (rd_go && lock_open && sel_zero) |=> (rdata_q[6:0] == 7'h28)) else $error("reg zero fixed bits");
  one_fixed_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (rd_go && lock_open && sel_one) |=> (rdata_q & 8'h73) == 8'h10) else $error("reg one fixed bits");
  two_fixed_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (rd_go && lock_open && sel_two) |=> (rdata_q & 8'h77) == 8'h00) else $error("reg two fixed bits");
  three_fixed_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (rd_go && lock_open && sel_three) |=> (rdata_q & 8'h7a) == 8'h70) else $error("reg three fixed bits");
  par_power_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_ok && sel_one) |=> ##1 ctl_q.par_power == $past(req.wdata[2], 2)) else $error("parallel power lag");
  pin_fn_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_ok && sel_three) |=> ##1 ctl_q.pin_fn == gcr_pin_fn_t'({$past(req.wdata[7], 2), $past(req.wdata[2], 2)}))
    else $error("pin function lag");
  ser_power_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_ok && sel_two) |=> ##1 {ctl_q.ser2_power, ctl_q.ser1_power} == {$past(req.wdata[7], 2), $past(req.wdata[3], 2)})
    else $error("serial power lag");
  printer_mode_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_ok && sel_one) |=> ##1 ctl_q.par_printer_mode == $past(req.wdata[3], 2))
    else $error("printer mode lag");
  valid_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_ok && sel_zero) |=> ##1 ctl_q.valid_flag == $past(req.wdata[7], 2))
    else $error("valid flag lag");
  lock_copy_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> unlocked_q == $past(lock_open)) else $error("lock copy wrong");
  read_only_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !rd_go |=> (!rvalid_q && rdata_q == 8'h00)) else $error("answer without read");

endmodule

// *** bench/gcr_host_model.sv ***
/*
  host model: runs one configuration register cycle per call on req.
  assumes a single caller process and the strobe timing of gcr_regs.
*/
`timescale 1ns/1ps
module gcr_host_model
  import gcr_pkg::*;
(
  // clock
  input  wire logic       ref_clk,
  // request and answer
  output gcr_req_t        req,
  input  wire logic [7:0] rdata_q,
  input  wire logic       rvalid_q
);
  initial req = '0;

  // ----------------------------------------
  // one strobe cycle, then idle
  // ----------------------------------------
  // released index and data show the inverse so stale values never match
  task automatic cyc(input logic cfg, input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd_val, output logic rd_ok);
    @(posedge ref_clk);
    req <= '{cfg_state: cfg, index: idx, wr: wr, rd: !wr, wdata: wd};
    @(posedge ref_clk);
    req <= '{cfg_state: cfg, index: ~idx, wr: 1'b0, rd: 1'b0, wdata: ~wd};
    #1;
    rd_val = rdata_q;
    rd_ok  = rvalid_q;
  endtask
endmodule

// *** bench/tb_top.sv ***
/*
  self-checking bench for gcr_regs: defaults, fixed bits, pin codes,
  access gating, power gates and lock.
  assumes gcr_host_model drives the request struct.
*/
`timescale 1ns/1ps
module tb_top
  import gcr_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        ref_clk;
  logic        reset_n;
  gcr_req_t    req;
  logic [7:0]  rdata_q;
  logic        rvalid_q;
  logic [10:0] par_base;
  logic [10:0] ser1_base;
  logic [10:0] ser2_base;
  logic [2:0]  hit;
  gcr_ctl_t    ctl_q;
  logic [2:0]  dev_enable_q;
  logic [2:0]  decode_en_q;
  logic [2:0]  range_check_q;
  logic        unlocked_q;
  int          num_errors;
  int          n_checks;

  gcr_regs gcr_regs_inst (.ref_clk(ref_clk), .reset_n(reset_n), .req(req), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q), .par_base(par_base), .ser1_base(ser1_base), .ser2_base(ser2_base),
    .par_hit(hit[0]), .ser1_hit(hit[1]), .ser2_hit(hit[2]), .ctl_q(ctl_q),
    .dev_enable_q(dev_enable_q), .decode_en_q(decode_en_q), .range_check_q(range_check_q),
    .unlocked_q(unlocked_q));
  gcr_host_model gcr_host_model_inst (.ref_clk(ref_clk), .req(req), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] pw();
    return {ctl_q.pin_fn, ctl_q.pgood_reserved, ctl_q.valid_flag, ctl_q.par_power,
            ctl_q.par_printer_mode, ctl_q.ser1_power, ctl_q.ser2_power};
  endfunction
  task automatic acc(input logic cfg, input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic ok_exp, input logic [7:0] exp);
    logic [7:0] v;
    logic       ok;
    gcr_host_model_inst.cyc(cfg, w, idx, d, v, ok);
    chk({7'h00, ok}, {7'h00, ok_exp});
    if (ok_exp) chk(v, exp);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    acc(1'b1, 1'b1, idx, d, 1'b0, 8'h00);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    acc(1'b1, 1'b0, idx, 8'h00, 1'b1, exp);
  endtask
  task automatic reset_for(input int n);
    reset_n <= 1'b0;
    repeat (n) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults;
    rd(8'h00, 8'h28);
    rd(8'h01, 8'h9c);
    rd(8'h02, 8'h88);
    rd(8'h03, 8'h70);
    chk(pw(), 8'h0f);
    chk({7'h00, unlocked_q}, 8'h01);
    $display("test defaults done");
  endtask
  task automatic t_fixed;
    wr(8'h00, 8'hff);
    rd(8'h00, 8'ha8);
    chk(pw(), 8'h1f);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h28);
    wr(8'h02, 8'h00);
    rd(8'h02, 8'h00);
    chk(pw(), 8'h0c);
    chk({5'h00, dev_enable_q}, 8'h01);
    wr(8'h02, 8'hff);
    rd(8'h02, 8'h88);
    for (int i = 0; i < 4; i++) begin
      wr(8'h03, 8'h7b | {i[1], 4'h0, i[0], 2'h0});
      rd(8'h03, 8'h71 | {i[1], 4'h0, i[0], 2'h0});
      chk(pw(), {i[1:0], 6'h2f});
    end
    wr(8'h03, 8'h00);
    rd(8'h03, 8'h70);
    $display("test fixed bits done");
  endtask
  task automatic t_gating;
    acc(1'b0, 1'b1, 8'h00, 8'h80, 1'b0, 8'h00);
    acc(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00);
    wr(8'h04, 8'h80);
    acc(1'b1, 1'b0, 8'h04, 8'h00, 1'b0, 8'h00);
    rd(8'h00, 8'h28);
    $display("test gating done");
  endtask
  task automatic t_power;
    wr(8'h01, 8'h80);
    rd(8'h01, 8'h90);
    chk(pw(), 8'h03);
    @(posedge ref_clk);
    par_base  <= 11'h100;
    ser1_base <= 11'h3f8;
    ser2_base <= 11'h0ff;
    hit       <= 3'b111;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({5'h00, dev_enable_q}, 8'h06);
    chk({5'h00, decode_en_q}, 8'h03);
    chk({5'h00, range_check_q}, 8'h03);
    @(posedge ref_clk);
    par_base <= 11'h0ff;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({5'h00, decode_en_q}, 8'h02);
    chk({5'h00, range_check_q}, 8'h02);
    wr(8'h01, 8'hff);
    rd(8'h01, 8'h9c);
    $display("test power done");
  endtask
  task automatic t_lock;
    wr(8'h01, 8'h0c);
    rd(8'h01, 8'hff);
    chk({7'h00, unlocked_q}, 8'h00);
    wr(8'h00, 8'h80);
    wr(8'h02, 8'h00);
    wr(8'h01, 8'h8c);
    rd(8'h00, 8'hff);
    chk(pw(), 8'h0f);
    chk({7'h00, unlocked_q}, 8'h00);
    @(posedge ref_clk);
    reset_for(2);
    rd(8'h01, 8'h9c);
    chk({7'h00, unlocked_q}, 8'h01);
    $display("test lock done");
  endtask

  // ----------------------------------------
  // verdict
  // ----------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    results();
  end

  initial begin
    num_errors = 0;
    n_checks   = 0;
    reset_n    = 1'b0;
    par_base   = 11'h000;
    ser1_base  = 11'h000;
    ser2_base  = 11'h000;
    hit        = 3'b000;
    reset_for(6);
    t_defaults();
    t_fixed();
    t_gating();
    t_power();
    t_lock();
    results();
  end
endmodule
